// *** inc/psram_host_pkg.sv ***
package psram_host_pkg;
  // ---------------------------------------------------------------
  // bus widths and clock
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 22;
  localparam int DATA_W    = 16;
  localparam int CLK_PS    = 8000;

  // ---------------------------------------------------------------
  // timing figures in ns and derived cycle counts
  // ---------------------------------------------------------------
  localparam int T_RC_NS   = 70;  // read cycle, least
  localparam int T_AA_NS   = 70;  // access time, most
  localparam int T_WC_NS   = 70;  // write cycle, least
  localparam int T_PWE_NS  = 55;  // write strobe pulse, least
  localparam int T_SD_NS   = 25;  // data setup to write end
  localparam int T_HZ_NS   = 25;  // memory release of data lines
  localparam int T_SK_NS   = 10;  // address skew allowance

  localparam int RD_CYC  = (T_AA_NS * 1000 + CLK_PS - 1) / CLK_PS + 2;
  localparam int PWE_CYC = (T_PWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HZ_CYC  = (T_HZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SD_CYC  = (T_SD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REC_CYC =
    ((T_WC_NS - T_PWE_NS) * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W   = 5;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              write;      // 1 write, 0 read
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lane_en;    // [1] upper byte, [0] lower byte
  } req_t;

  typedef struct packed {
    logic              chip_en_n;
    logic              select_hi;
    logic              write_n;
    logic              out_en_n;
    logic              upper_lane_n;
    logic              lower_lane_n;
  } ctl_t;

  localparam ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// *** hw/psram_host.sv ***
// Behaviour
// - a write starts only while strobe, both chip enables and a lane are active together.
// - write data setup and hold are timed against the edge that ends the write.
// - the host never drives data while the memory may still drive the lines.
// - the write strobe stays high through every read cycle.
// - address lines settle within the skew limit after the read cycle begins.
// - reads start with chip enable, addresses already stable beforehand.
// - address-paced reads keep both enables asserted and only change address.
// - the two lane enables select which bytes are written.
module psram_host
  import psram_host_pkg::*;
(
  input  wire logic              clk,          // 125 MHz clock
  input  wire logic              reset,        // sync, active high
  input  wire req_t              req,          // request fields
  input  wire logic              req_valid,    // request offered
  output logic                   req_ready,    // request taken
  output logic [DATA_W-1:0]      rd_data,      // read word
  output logic                   rd_valid,     // read word pulse
  output logic [ADDR_W-1:0]      mem_addr,     // address pins
  output ctl_t                   mem_ctl,      // control pins
  output logic [DATA_W-1:0]      mem_dq_out,   // data pins out
  output logic                   mem_dq_oe,    // data pins driven
  input  wire logic [DATA_W-1:0] mem_dq_in     // data pins in
);

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  // setup holds the chip deselected while address and lanes settle
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_RD, ST_WR_TURN, ST_WR_PULSE, ST_WR_HOLD
  } state_t;

  state_t              state_ff, nxt_state;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
  ctl_t                ctl_ff, nxt_ctl;
  logic [ADDR_W-1:0]   addr_ff, nxt_addr;
  logic [DATA_W-1:0]   dq_out_ff, nxt_dq_out;
  logic                dq_oe_ff, nxt_dq_oe;
  logic [DATA_W-1:0]   rd_data_ff, nxt_rd_data;
  logic                rd_valid_ff, nxt_rd_valid;
  logic                ready_ff, nxt_ready;
  logic [DATA_W-1:0]   dq_s1_ff, dq_s2_ff;
  logic                out_was_on_ff, nxt_out_was_on;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic take     = ready_ff & req_valid;
  wire logic cnt_done = (cnt_ff == '0);
  // read with the same enables still on: only the address moves
  wire logic same_rd  = (state_ff == ST_RD) & cnt_done & take & ~req.write
                        & (req.lane_en == ~{ctl_ff.upper_lane_n,
                                            ctl_ff.lower_lane_n});
  // any other take restarts from a deselected chip, never dropped
  wire logic load     = take & ~same_rd;

  // data pins pass two flops before use, they come from off chip
  always_ff @(posedge clk) begin
    dq_s1_ff <= mem_dq_in;
    dq_s2_ff <= dq_s1_ff;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_done ? cnt_ff : cnt_ff - 1'b1;
    nxt_ctl        = ctl_ff;
    nxt_addr       = addr_ff;
    nxt_dq_out     = dq_out_ff;
    nxt_dq_oe      = dq_oe_ff;
    nxt_rd_data    = rd_data_ff;
    nxt_rd_valid   = 1'b0;
    nxt_ready      = 1'b0;
    nxt_out_was_on = out_was_on_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // ready only once the release wait after a read has run out
        nxt_ready = 1'b1;
        if (take) begin
          nxt_ready = 1'b0;
        end
      end
      ST_SETUP: begin
        // chip enable follows an address already settled
        nxt_ctl.chip_en_n = 1'b0;
        nxt_ctl.select_hi = 1'b1;
        if (ctl_ff.out_en_n) begin
          // wait out release only if outputs were on
          nxt_cnt = out_was_on_ff ? CNT_W'(HZ_CYC) : '0;
          nxt_state = ST_WR_TURN;
        end else begin
          nxt_out_was_on = 1'b1;
          nxt_cnt = CNT_W'(RD_CYC);
          nxt_state = ST_RD;
        end
      end
      ST_RD: begin
        if (cnt_done && !ready_ff) begin
          // word settled: hand it over, ready one cycle for a paged read
          nxt_rd_data = dq_s2_ff;
          nxt_rd_valid = 1'b1;
          nxt_ready = 1'b1;
        end else if (cnt_done && same_rd) begin
          // enables stay, new address starts access
          // address switched in one edge, well inside skew
          nxt_addr = req.addr;
          nxt_cnt = CNT_W'(RD_CYC);
        end else if (cnt_done && !take) begin
          // nothing follows: deselect and let the lines float
          nxt_ctl = CTL_IDLE;
          nxt_cnt = CNT_W'(HZ_CYC);
          nxt_state = ST_IDLE;
        end
      end
      ST_WR_TURN: begin
        if (cnt_done) begin
          // host drives only after memory lines released
          nxt_out_was_on = 1'b0;
          nxt_dq_oe = 1'b1;
          // strobe joins the other active signals
          // lane enables pick the written bytes
          nxt_ctl.write_n = 1'b0;
          nxt_cnt = CNT_W'(PWE_CYC > SD_CYC ? PWE_CYC : SD_CYC);
          nxt_state = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          // strobe rising alone ends the write
          // data held past this terminating edge
          nxt_ctl.write_n = 1'b1;
          nxt_cnt = CNT_W'(REC_CYC);
          nxt_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (cnt_done) begin
          // chip enable drops with strobe already high
          nxt_ctl = CTL_IDLE;
          nxt_dq_oe = 1'b0;
          nxt_state = ST_IDLE;
          nxt_ready = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    // a new request other than a paged read first puts address, lanes and direction on the pins
    // with the chip deselected, so its address never moves under select
    if (load) begin
      nxt_addr = req.addr;
      nxt_ctl = CTL_IDLE;
      // output enable high on writes so the memory floats
      // strobe stays high, it only falls inside a write
      nxt_ctl.out_en_n = req.write;
      nxt_ctl.upper_lane_n = ~req.lane_en[1];
      nxt_ctl.lower_lane_n = ~req.lane_en[0];
      if (req.write) begin
        nxt_dq_out = req.wdata;
      end
      nxt_state = ST_SETUP;
    end
    // idle recovery counter gates the ready flag after a read
    if (state_ff == ST_IDLE && !cnt_done && !take) begin
      nxt_ready = 1'b0;
    end
    if (state_ff == ST_IDLE && cnt_done) begin
      nxt_out_was_on = out_was_on_ff;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // one bank, reset puts every pin at its idle level
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= '0;
      ctl_ff        <= CTL_IDLE;
      addr_ff       <= '0;
      dq_out_ff     <= '0;
      dq_oe_ff      <= 1'b0;
      rd_data_ff    <= '0;
      rd_valid_ff   <= 1'b0;
      ready_ff      <= 1'b0;
      out_was_on_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      ctl_ff        <= nxt_ctl;
      addr_ff       <= nxt_addr;
      dq_out_ff     <= nxt_dq_out;
      dq_oe_ff      <= nxt_dq_oe;
      rd_data_ff    <= nxt_rd_data;
      rd_valid_ff   <= nxt_rd_valid;
      ready_ff      <= nxt_ready;
      out_was_on_ff <= nxt_out_was_on;
    end
  end

  // outputs straight from flops
  assign req_ready  = ready_ff;
  assign rd_data    = rd_data_ff;
  assign rd_valid   = rd_valid_ff;
  assign mem_addr   = addr_ff;
  assign mem_ctl    = ctl_ff;
  assign mem_dq_out = dq_out_ff;
  assign mem_dq_oe  = dq_oe_ff;

endmodule

// *** testbench/psram_host_monitor.sv ***
// ----------------
// host pin checks
// ----------------
module psram_host_chk
  import psram_host_pkg::*;
(
  input logic              clk,        // clock
  input logic              reset,      // sync reset
  input req_t              req,        // request
  input logic              req_valid,  // offered
  input logic              req_ready,  // taken
  input logic              rd_valid,   // read pulse
  input logic [ADDR_W-1:0] mem_addr,   // address pins
  input ctl_t              mem_ctl,    // control pins
  input logic [DATA_W-1:0] mem_dq_out, // data out
  input logic              mem_dq_oe   // data driven
);
  timeunit 1ns;
  timeprecision 100ps;
  ctl_t       c;
  logic [1:0] lane_ff;
  logic       take;
  // shorthand for the pins and the take
  assign c    = mem_ctl;
  assign take = req_valid && req_ready;
  // lanes of the request in flight
  always_ff @(posedge clk) if (take) lane_ff <= req.lane_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wr_start_a: assert property (
    $fell(c.write_n) |-> !c.chip_en_n && c.select_hi)
    else $error("write began unselected");
  data_hold_a: assert property (
    $rose(c.write_n) |-> mem_dq_oe && $stable(mem_dq_out) && !c.chip_en_n)
    else $error("data moved at write end");
  // memory may drive up to 25 ns after output enable leaves
  no_clash_a: assert property (
    mem_dq_oe |-> c.out_en_n && $past(c.out_en_n, 4))
    else $error("host drove data too soon");
  rd_strobe_a: assert property (
    !c.out_en_n |-> c.write_n) else $error("strobe low in read");
  addr_hold_a: assert property (
    !c.chip_en_n && !$past(c.chip_en_n) && !c.out_en_n && !$past(rd_valid)
    |-> $stable(mem_addr)) else $error("address moved in read");
  addr_first_a: assert property (
    take && c.chip_en_n |=> (c.chip_en_n && mem_addr == $past(req.addr))
    ##1 (!c.chip_en_n && $stable(mem_addr)))
    else $error("address not set with select");
  page_keep_a: assert property (
    take && !req.write && !c.out_en_n
    && req.lane_en == ~{c.upper_lane_n, c.lower_lane_n}
    |=> !c.chip_en_n && !c.out_en_n) else $error("paged read dropped");
  lane_map_a: assert property (
    !c.chip_en_n |-> {c.upper_lane_n, c.lower_lane_n} == ~lane_ff)
    else $error("lane pins differ from request");
  cover property (take && req.write);
  cover property (take && !c.out_en_n);
  cover property ($rose(mem_dq_oe));
endmodule

bind psram_host psram_host_chk chk_u (.clk, .reset, .req, .req_valid,
  .req_ready, .rd_valid, .mem_addr, .mem_ctl, .mem_dq_out, .mem_dq_oe);

// *** testbench/psram_model.sv ***
// ----------------
// memory die model
// ----------------
module psram_model
  import psram_host_pkg::*;
(
  input  logic              clk,   // clock
  input  logic [ADDR_W-1:0] addr,  // address pins
  input  ctl_t              ctl,   // control pins
  input  logic [DATA_W-1:0] dq_in, // host data
  input  logic              dq_oe, // host drives
  output logic [DATA_W-1:0] dq     // memory data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last_ff = '0;
  logic [DATA_W-1:0] wd;
  logic              sel, wr, rd;
  // write only while all enables overlap
  assign sel = !ctl.chip_en_n && ctl.select_hi;
  assign wr  = sel && !ctl.write_n;
  // drive only in a selected read
  assign rd  = sel && ctl.write_n && !ctl.out_en_n;
  // released lines flip, so stale data never looks valid
  assign dq  = rd ? mem[addr[3:0]] : ~last_ff;
  assign wd  = dq_oe ? dq_in : ~last_ff;
  // last overlap cycle wins, per lane
  always_ff @(posedge clk) begin
    last_ff <= dq;
    if (wr && !ctl.upper_lane_n) mem[addr[3:0]][15:8] <= wd[15:8];
    if (wr && !ctl.lower_lane_n) mem[addr[3:0]][7:0] <= wd[7:0];
  end
endmodule

// *** testbench/psram_host_tb.sv ***
module psram_host_tb
  import psram_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  req_t              req = '0;
  logic              req_valid = 1'b0;
  logic              req_ready, rd_valid, mem_dq_oe;
  logic [DATA_W-1:0] rd_data, mem_dq_out, mem_dq_in;
  logic [ADDR_W-1:0] mem_addr;
  ctl_t              mem_ctl;
  int                n_errors = 0;
  int                samples_checked = 0;
  logic [15:0]       rd_q [8];
  int                rd_in = 0;
  int                rd_out = 0;

  always #4 clk = ~clk;

  psram_host dut_u (.clk, .reset, .req, .req_valid, .req_ready, .rd_data,
    .rd_valid, .mem_addr, .mem_ctl, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
  psram_model mem_u (.clk, .addr(mem_addr), .ctl(mem_ctl),
    .dq_in(mem_dq_out), .dq_oe(mem_dq_oe), .dq(mem_dq_in));

  // every read word is kept, so a scenario still offering its next
  // request does not miss the one-cycle pulse
  always @(posedge clk) begin
    if (rd_valid) begin
      rd_q[rd_in % 8] <= rd_data;
      rd_in <= rd_in + 1;
    end
  end

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp16(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // offer one request, keep it until taken; hold keeps valid up
  task automatic offer(logic w, logic [3:0] a, logic [15:0] d,
                       logic [1:0] l, logic hold);
    int n = 0;
    @(posedge clk);
    #1;
    req = '{w, {18'h0, a}, d, l};
    req_valid = 1'b1;
    while (!req_ready && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp16("req_ready", 16'h0001, {15'h0, req_ready});
    @(posedge clk);
    #1;
    if (!hold) req_valid = 1'b0;
  endtask

  // wait a bounded time for the next kept read word
  task automatic get(logic [15:0] exp);
    int n = 0;
    while (rd_out == rd_in && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp16("rd_valid", 16'h0001, {15'h0, rd_out != rd_in});
    if (rd_out != rd_in) begin
      cmp16("rd_data", exp, rd_q[rd_out % 8]);
      rd_out++;
    end
  endtask

  task automatic t_word();
    offer(1'b1, 4'h3, 16'ha5c3, 2'h3, 1'b0);
    offer(1'b0, 4'h3, 16'h0000, 2'h3, 1'b0);
    get(16'ha5c3);
    $display("t_word done");
  endtask

  task automatic t_lanes();
    offer(1'b1, 4'h5, 16'h1234, 2'h3, 1'b0);
    offer(1'b1, 4'h5, 16'hcdef, 2'h2, 1'b0);
    offer(1'b1, 4'h5, 16'h0099, 2'h1, 1'b0);
    offer(1'b0, 4'h5, 16'h0000, 2'h3, 1'b0);
    get(16'hcd99);
    $display("t_lanes done");
  endtask

  // second read waits for the first word, then pages on
  task automatic t_paged();
    offer(1'b1, 4'h6, 16'h1111, 2'h3, 1'b0);
    offer(1'b1, 4'h7, 16'h2222, 2'h3, 1'b0);
    offer(1'b0, 4'h6, 16'h0000, 2'h3, 1'b1);
    offer(1'b0, 4'h7, 16'h0000, 2'h3, 1'b0);
    get(16'h1111);
    get(16'h2222);
    $display("t_paged done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    t_word();
    t_lanes();
    t_paged();
    report_and_stop();
  end

  // watchdog well beyond the few hundred cycles used
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
endmodule
